/* hdl/pss_consts.svh */
// constants for the power-up strap sequencer
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_CLK_PERIOD_NS 20
`define PSS_STRAP_HOLD_NS 500
`define PSS_STRAP_HOLD_CYC ((`PSS_STRAP_HOLD_NS + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS)
`define PSS_INIT1_CYC 16
`define PSS_INIT2_CYC 64
`define PSS_MUTE_FRAMES 4
`define PSS_FRAME_CYC 32
`define PSS_I2C_ADDR_BASE 7'h18
`define PSS_STATE_INIT1 4'h1
`define PSS_STATE_WAIT 4'h2
`define PSS_STATE_INIT2 4'h4
`define PSS_STATE_ACTIVE 4'h8
`endif

/* hdl/pss_pkg.sv */
// types for the power-up strap sequencer
package pss_pkg;
   typedef enum logic [4:0] {
      PSS_OFF = 5'b0_0001,
      PSS_INIT1 = 5'b0_0010,
      PSS_WAIT = 5'b0_0100,
      PSS_INIT2 = 5'b0_1000,
      PSS_ACTIVE = 5'b1_0000
   } pss_state_t;
   typedef enum logic [1:0] {
      PSS_COMM_UART = 2'h0,
      PSS_COMM_I2C = 2'h1,
      PSS_COMM_SPI = 2'h2
   } pss_comm_t;
endpackage : pss_pkg

/* hdl/pss_sequencer.sv */
// start-up and shut-down sequencer with strap latching
//
// What this block does
// - clear release starts start-up in the first init stage
// - straps latched at clear release; host holds them 500 ns
// - auto mode goes straight from init one to init two
// - active starts sync output, muted frames before valid images
// - active drives busy low and accepts host traffic
// - traffic while disabled: ignored on UART and SPI, NACK on I2C
// - manual mode inserts a mode-wait state with busy low, traffic on
// - init two holds busy high and refuses host traffic
// - clear low during operation stops outputs and raises busy
// - two straps pick one of four stored operating modes
// - two straps pick I2C address 0x18..0x1B or a flash address
// - three straps latched, of which C and B pick UART, I2C or SPI host link
// - default is init one; state readable when busy is low
// - init one goes to mode-wait if undetermined, else init two
// - mode-wait holds until host sets output mode, then init two
// - init two sets up PLL, sensor, blocks, then goes active
`timescale 1ns/1ns
`include "pss_consts.svh"
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int INIT1_CYC = `PSS_INIT1_CYC,
   parameter int INIT2_CYC = `PSS_INIT2_CYC,
   parameter int MUTE_FRAMES = `PSS_MUTE_FRAMES,
   parameter int FRAME_CYC = `PSS_FRAME_CYC
)
(
   // clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   // pins from the host
   input wire logic CLEAR_N_IN,
   input wire logic MODE_STRAP_A_IN,
   input wire logic MODE_STRAP_B_IN,
   input wire logic ADDR_STRAP_A_IN,
   input wire logic ADDR_STRAP_B_IN,
   input wire logic COMM_STRAP_A_IN,
   input wire logic COMM_STRAP_B_IN,
   input wire logic COMM_STRAP_C_IN,
   // configuration from flash and sub-blocks
   input wire logic MANUAL_MODE_IN,
   input wire logic FLASH_ADDR_EN_IN,
   input wire logic [6:0] FLASH_ADDR_IN,
   // host traffic and mode set
   input wire logic HOST_REQ_IN,
   input wire logic HOST_MODE_SET_IN,
   // status and control outputs
   output logic STARTUP_BUSY_OUT,
   output logic [3:0] STATE_CODE_OUT,
   output logic COMM_EN_OUT,
   output logic HOST_ACCEPT_OUT,
   output logic I2C_NACK_OUT,
   output logic [1:0] OP_MODE_OUT,
   output logic [6:0] I2C_ADDR_OUT,
   output logic [1:0] COMM_SEL_OUT,
   output logic PLL_INIT_OUT,
   output logic SYNC_EN_OUT,
   output logic IMAGE_VALID_OUT
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int NPIN = 8;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] meta_q;
   logic [NPIN-1:0] sync_q;
   assign pin_raw = {CLEAR_N_IN, MODE_STRAP_B_IN, MODE_STRAP_A_IN,
      ADDR_STRAP_B_IN, ADDR_STRAP_A_IN, COMM_STRAP_C_IN,
      COMM_STRAP_B_IN, COMM_STRAP_A_IN};

   // two flops on every pin
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
      end
   end

   logic clear_n_s;
   logic clear_prev_q;
   logic clear_rise;
   assign clear_n_s = sync_q[7];
   assign clear_rise = clear_n_s & ~clear_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // state machine
   pss_state_t state_q;
   pss_state_t state_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [7:0] mute_q;
   logic [7:0] mute_d;
   logic init1_done;
   logic init2_done;
   logic frame_end;
   assign init1_done = (cnt_q == 16'(INIT1_CYC - 1));
   assign init2_done = (cnt_q == 16'(INIT2_CYC - 1));
   assign frame_end = (cnt_q == 16'(FRAME_CYC - 1));

   // next state and counters
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + 16'h0001;
      mute_d = mute_q;
      if (!clear_n_s)
      begin
         state_d = PSS_OFF;
         cnt_d = 16'h0000;
         mute_d = 8'h00;
      end
      else
      begin
         unique case (state_q)
            PSS_OFF:
            begin
               cnt_d = 16'h0000;
               if (clear_rise)
                  state_d = PSS_INIT1;
            end
            PSS_INIT1:
            begin
               if (init1_done)
               begin
                  cnt_d = 16'h0000;
                  if (MANUAL_MODE_IN)
                     state_d = PSS_WAIT;
                  else
                     state_d = PSS_INIT2;
               end
            end
            PSS_WAIT:
            begin
               cnt_d = 16'h0000;
               if (HOST_MODE_SET_IN)
                  state_d = PSS_INIT2;
            end
            PSS_INIT2:
            begin
               if (init2_done)
               begin
                  cnt_d = 16'h0000;
                  state_d = PSS_ACTIVE;
               end
            end
            PSS_ACTIVE:
            begin
               // count muted frames before images go valid
               if (frame_end)
               begin
                  cnt_d = 16'h0000;
                  if (mute_q != 8'(MUTE_FRAMES))
                     mute_d = mute_q + 8'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         state_q <= PSS_OFF;
         cnt_q <= 16'h0000;
         mute_q <= 8'h00;
         clear_prev_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         mute_q <= mute_d;
         clear_prev_q <= clear_n_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strap latch at clear release
   logic [1:0] mode_q;
   logic [1:0] addr_q;
   logic [2:0] comm_q;
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         mode_q <= 2'h0;
         addr_q <= 2'h0;
         comm_q <= 3'h0;
      end
      else if (clear_rise && state_q == PSS_OFF)
      begin
         mode_q <= {sync_q[6], sync_q[5]};
         addr_q <= {sync_q[3], sync_q[4]};
         comm_q <= sync_q[2:0];
      end
   end

   // strap decode
   logic [6:0] i2c_addr_d;
   pss_comm_t comm_sel;
   assign i2c_addr_d = FLASH_ADDR_EN_IN ? FLASH_ADDR_IN :
      (`PSS_I2C_ADDR_BASE | {5'h00, addr_q});
   assign comm_sel = comm_q[2] ? PSS_COMM_SPI :
      (comm_q[1] ? PSS_COMM_I2C : PSS_COMM_UART);

   // state code and traffic gating
   logic comm_en;
   logic [3:0] code_d;
   logic busy_d;
   assign comm_en = (state_q == PSS_WAIT) || (state_q == PSS_ACTIVE);
   assign busy_d = ~comm_en;
   assign code_d = (state_q == PSS_WAIT) ? `PSS_STATE_WAIT :
      (state_q == PSS_INIT2) ? `PSS_STATE_INIT2 :
      (state_q == PSS_ACTIVE) ? `PSS_STATE_ACTIVE :
      `PSS_STATE_INIT1;

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         STARTUP_BUSY_OUT <= 1'b1;
         STATE_CODE_OUT <= `PSS_STATE_INIT1;
         COMM_EN_OUT <= 1'b0;
         HOST_ACCEPT_OUT <= 1'b0;
         I2C_NACK_OUT <= 1'b0;
         OP_MODE_OUT <= 2'h0;
         I2C_ADDR_OUT <= `PSS_I2C_ADDR_BASE;
         COMM_SEL_OUT <= 2'h0;
         PLL_INIT_OUT <= 1'b0;
         SYNC_EN_OUT <= 1'b0;
         IMAGE_VALID_OUT <= 1'b0;
      end
      else
      begin
         STARTUP_BUSY_OUT <= busy_d;
         STATE_CODE_OUT <= comm_en ? code_d : STATE_CODE_OUT;
         COMM_EN_OUT <= comm_en;
         HOST_ACCEPT_OUT <= HOST_REQ_IN & comm_en;
         I2C_NACK_OUT <= HOST_REQ_IN & ~comm_en &
            (comm_sel == PSS_COMM_I2C);
         OP_MODE_OUT <= mode_q;
         I2C_ADDR_OUT <= i2c_addr_d;
         COMM_SEL_OUT <= comm_sel;
         PLL_INIT_OUT <= (state_q == PSS_INIT2);
         SYNC_EN_OUT <= (state_q == PSS_ACTIVE);
         IMAGE_VALID_OUT <= (state_q == PSS_ACTIVE) &&
            (mute_q == 8'(MUTE_FRAMES));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_release;
      clear_rise && state_q == PSS_OFF;
   endsequence
   sequence s_init1;
      state_q == PSS_INIT1;
   endsequence
   // init one finishing while the clear pin stays released
   sequence s_init1_end;
      s_init1 and (init1_done && clear_n_s);
   endsequence

   a_release_init1: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) s_release |=> s_init1)
      else $error("release did not enter init one");
   a_auto_skip: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) s_init1_end and !MANUAL_MODE_IN
      |=> state_q == PSS_INIT2)
      else $error("auto mode did not go to init two");
   a_manual_wait: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) s_init1_end and MANUAL_MODE_IN
      |=> state_q == PSS_WAIT)
      else $error("manual mode did not wait");
   a_wait_hold: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_WAIT && clear_n_s
      && !HOST_MODE_SET_IN |=> state_q == PSS_WAIT)
      else $error("mode wait left without mode set");
   // mode wait opens the host link with busy low
   a_wait_open: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_WAIT |=>
      !STARTUP_BUSY_OUT && COMM_EN_OUT)
      else $error("mode wait with busy high or link shut");
   a_init2_busy: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_INIT2 |=>
      STARTUP_BUSY_OUT && !HOST_ACCEPT_OUT)
      else $error("busy low during init two");
   a_init2_done: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_INIT2 && init2_done
      && clear_n_s |=> state_q == PSS_ACTIVE)
      else $error("init two did not go active");
   a_active_busy: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_ACTIVE |=>
      !STARTUP_BUSY_OUT && SYNC_EN_OUT)
      else $error("active without busy low and sync");
   a_accept_on: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) HOST_REQ_IN && comm_en
      |=> HOST_ACCEPT_OUT && !I2C_NACK_OUT)
      else $error("open link did not accept traffic");
   a_clear_stop: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) !clear_n_s |=> ##1
      STARTUP_BUSY_OUT && !SYNC_EN_OUT && !IMAGE_VALID_OUT)
      else $error("outputs not stopped on clear");
   // pins turn into plain io after release, so the latch must not follow
   a_strap_keep: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) !(clear_rise && state_q == PSS_OFF)
      |=> $stable({mode_q, addr_q, comm_q}))
      else $error("straps reloaded outside release");
   a_nack_i2c: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) HOST_REQ_IN && !comm_en
      && comm_sel == PSS_COMM_I2C |=> I2C_NACK_OUT && !HOST_ACCEPT_OUT)
      else $error("no nack for refused i2c traffic");
   a_quiet_link: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) HOST_REQ_IN && !comm_en
      && comm_sel != PSS_COMM_I2C |=> !I2C_NACK_OUT && !HOST_ACCEPT_OUT)
      else $error("refused uart or spi traffic answered");
   a_mute_first: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) $rose(SYNC_EN_OUT) |-> !IMAGE_VALID_OUT)
      else $error("valid image without muted frames");
   a_addr_decode: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) !FLASH_ADDR_EN_IN && addr_q == 2'h2
      |=> I2C_ADDR_OUT == 7'h1A)
      else $error("wrong strap address");
   // host reads a distinct code in each state it can see
   a_code_wait: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_WAIT |=>
      STATE_CODE_OUT == `PSS_STATE_WAIT)
      else $error("wrong code in mode wait");
   a_code_active: assert property (@(posedge CORE_CLK_IN)
      disable iff (SYS_RST_IN) state_q == PSS_ACTIVE |=>
      STATE_CODE_OUT == `PSS_STATE_ACTIVE)
      else $error("wrong code in active");

endmodule : pss_sequencer

/* verification/pss_host_model.sv */
// host-side model driving the clear pin and the strap pins
`timescale 1ns/1ns
module pss_host_model
#(
   parameter int HOLD_CYC = 26
)
(
   // clock, run request and strap values
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic [6:0] strap_in,
   // pins towards the device
   output logic clear_n_out = 1'b0,
   output logic [6:0] strap_out
);
   logic [5:0] hold_q = 6'h00;
   logic released;
   ////////////////////////////////////////////////////////////////////////
   // clear follows run; straps hold for the set time after release
   always_ff @(posedge clk_in)
   begin
      clear_n_out <= run_in;
      if (!run_in)
         hold_q <= 6'h00;
      else if (int'(hold_q) != HOLD_CYC)
         hold_q <= hold_q + 6'h01;
   end
   // once let go, the pins no longer show the latched value
   assign released = run_in && (int'(hold_q) == HOLD_CYC);
   assign strap_out = released ? ~strap_in : strap_in;
endmodule : pss_host_model

/* verification/pss_sequencer_tb.sv */
// self-checking bench for the start-up sequencer
`timescale 1ns/1ns
module pss_sequencer_tb;
   import pss_pkg::*;
   localparam int FRM = 8;
   localparam int MUTES = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b0;
   logic [6:0] strap = 7'h00;
   logic [6:0] pin;
   logic clr_n, manual = 1'b0, fl_en = 1'b0, req = 1'b0, mset = 1'b0;
   logic busy, comm_en, acc, nack, pll, sync, img;
   logic [3:0] code;
   logic [1:0] opm, csel;
   logic [6:0] addr;
   logic [2:0] cs [4] = '{3'h0, 3'h2, 3'h1, 3'h7};
   logic [1:0] ce [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   // clock and cycle ceiling
   initial
   begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   pss_host_model HOST (.clk_in(clk), .run_in(run), .strap_in(strap),
      .clear_n_out(clr_n), .strap_out(pin));
   pss_sequencer #(.INIT1_CYC(4), .INIT2_CYC(6), .MUTE_FRAMES(MUTES),
      .FRAME_CYC(FRM)) DUT (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
      .CLEAR_N_IN(clr_n), .MODE_STRAP_B_IN(pin[6]),
      .MODE_STRAP_A_IN(pin[5]), .ADDR_STRAP_A_IN(pin[4]),
      .ADDR_STRAP_B_IN(pin[3]), .COMM_STRAP_A_IN(pin[2]),
      .COMM_STRAP_B_IN(pin[1]), .COMM_STRAP_C_IN(pin[0]),
      .MANUAL_MODE_IN(manual), .FLASH_ADDR_EN_IN(fl_en),
      .FLASH_ADDR_IN(7'h55), .HOST_REQ_IN(req), .HOST_MODE_SET_IN(mset),
      .STARTUP_BUSY_OUT(busy), .STATE_CODE_OUT(code),
      .COMM_EN_OUT(comm_en), .HOST_ACCEPT_OUT(acc), .I2C_NACK_OUT(nack),
      .OP_MODE_OUT(opm), .I2C_ADDR_OUT(addr), .COMM_SEL_OUT(csel),
      .PLL_INIT_OUT(pll), .SYNC_EN_OUT(sync), .IMAGE_VALID_OUT(img));
   ////////////////////////////////////////////////////////////////////////
   // compare one value and count it
   task check(input logic [6:0] seen, input logic [6:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task start(input logic [6:0] s, input logic man);
      run = 1'b0;
      strap = s;
      manual = man;
      tick(2);
      run = 1'b1;
   endtask : start
   task wait_busy(input logic lvl);
      while (busy !== lvl) tick(1);
   endtask : wait_busy
   // one host transaction; the answer lands one edge later
   task host_req(input logic a, input logic n);
      req = 1'b1;
      tick(1);
      req = 1'b0;
      check(acc, a);
      check(nack, n);
   endtask : host_req
   task wrap_up;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////
   // one start-up per strap set, auto and manual alternating
   initial
   begin
      tick(3);
      rst = 1'b0;
      check(busy, 1'b1);
      check(code, 4'h1);
      for (int i = 0; i < 4; i++)
      begin
         fl_en = (i == 3);
         start({i[1:0], i[1:0], cs[i]}, i[0]);
         tick(5);
         host_req(1'b0, ce[i] == 2'h1);
         if (i[0])
         begin
            wait_busy(1'b0);
            check(code, 4'h2);
            check(comm_en, 1'b1);
            check(sync, 1'b0);
            host_req(1'b1, 1'b0);
            mset = 1'b1;
            tick(1);
            mset = 1'b0;
            tick(3);
            check(busy, 1'b1);
            check(pll, 1'b1);
            host_req(1'b0, ce[i] == 2'h1);
         end
         wait_busy(1'b0);
         check(code, 4'h8);
         check(pll, 1'b0);
         check(sync, 1'b1);
         check(opm, i[1:0]);
         check(addr, fl_en ? 7'h55 : 7'h18 | i[1:0]);
         check(csel, ce[i]);
         host_req(1'b1, 1'b0);
         tick(2);
         check(img, 1'b0);
         // last muted cycle, then the first valid one
         tick(MUTES * FRM - 4);
         check(img, 1'b0);
         tick(1);
         check(img, 1'b1);
         // straps are let go by now; the latched mode must stay
         check(opm, i[1:0]);
         run = 1'b0;
         tick(5);
         check(busy, 1'b1);
         check({sync, img}, 2'h0);
      end
      wrap_up();
   end
endmodule : pss_sequencer_tb
